// ---- design/stp_segment_trap.sv ----
// Segment range check, trap request and acknowledge logic
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module stp_segment_trap
  import stp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Bus cycle being checked
  input  wire logic        acc_valid,
  input  wire logic        acc_dma,
  input  wire logic        acc_fetch,
  input  wire logic        acc_write,
  input  wire logic [6:0]  acc_seg,
  input  wire logic [15:0] acc_off,
  input  wire logic [7:0]  seg_limit,
  input  wire logic        stack_direction_warning_flag,
  // Processor sequencing
  input  wire logic        instr_end,
  input  wire logic        trap_ack,
  // Command port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Trap pins
  output logic             seg_trap_n,
  output logic             suppress_n,
  output logic      [7:0]  ad_hi_out,
  output logic      [7:0]  ad_hi_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  stp_state_t  state_reg, state_next;
  logic        seg_trap_n_reg, seg_trap_n_next;
  logic        suppress_n_reg, suppress_n_next;
  logic        hold_reg, hold_next;
  logic        ack_req_reg, ack_req_next;
  logic [7:0]  ad_out_reg, ad_out_next;
  logic [7:0]  ad_oe_reg, ad_oe_next;
  logic [7:0]  mode_reg, mode_next;
  logic        len_viol_reg, len_viol_next;
  logic        pri_warn_reg, pri_warn_next;
  logic        secondary_write_warning_flag_reg;
  logic        secondary_write_warning_flag_next;
  logic        fatal_condition_flag_reg, fatal_condition_flag_next;
  logic        frozen_reg, frozen_next;
  logic [6:0]  inst_seg_reg, inst_seg_next;
  logic [7:0]  inst_off_reg, inst_off_next;
  logic [6:0]  viol_seg_reg, viol_seg_next;
  logic [7:0]  viol_off_reg, viol_off_next;
  logic [7:0]  rdata_reg, rdata_next;

  // ----------------------------------------------------------------
  // Range check
  // ----------------------------------------------------------------
  logic [7:0] off_hi;
  logic       in_range, warn_zone, ignored, chk, cpu_chk;
  logic       viol, warn, in_swap, trap_pend, raise, sup_now, cmd_wr;
  logic [2:0] unit_identifier_field;

  assign off_hi                = acc_off[15:8];
  assign in_swap               = (state_reg == ST_SWAP);
  assign trap_pend             = ~seg_trap_n_reg;
  assign unit_identifier_field =
    mode_reg[STP_MODE_UNIT_LSB +: STP_UNIT_W];
  assign cmd_wr                = reg_wr & (reg_addr == STP_ADDR_CMD);

  // limit compare
  // Only the upper offset byte matters, so the check is one 8-bit compare
  // and finishes combinationally inside the address phase.
  // same-cycle compare
  assign in_range  = stack_direction_warning_flag ? (off_hi >= seg_limit)
                                                  : (off_hi <= seg_limit);
  assign warn_zone = stack_direction_warning_flag & acc_write &
                     (off_hi == seg_limit);
  // aborted fetch dropped
  // Any CPU fetch while a request waits is the dummy fetch; a trade-off
  // is that remaining opcode words of that instruction go unchecked.
  assign ignored   = acc_fetch & ~acc_dma & trap_pend &
                     (state_reg != ST_ACK);
  assign chk       = acc_valid & ~ignored & (state_reg != ST_ACK);
  assign cpu_chk   = chk & ~acc_dma;
  assign viol      = chk & ~in_range;
  assign warn      = chk & in_range & warn_zone;

  assign raise = cpu_chk &
                 (viol ? ~fatal_condition_flag_reg
                       : (warn & ~secondary_write_warning_flag_reg));

  assign sup_now = chk & (acc_dma ? viol : (~in_swap & (viol | hold_reg)));

  // ----------------------------------------------------------------
  // Sequencing and trap pins
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next      = state_reg;
    seg_trap_n_next = seg_trap_n_reg;
    suppress_n_next = suppress_n_reg;
    hold_next       = hold_reg;
    ack_req_next    = ack_req_reg;
    unique case (state_reg)
      ST_RUN, ST_SWAP:
      begin
        if (trap_ack)
        begin
          state_next   = ST_ACK;
          ack_req_next = trap_pend;
        end
        else if (in_swap & acc_valid & acc_fetch & ~acc_dma)
        begin
          state_next = ST_RUN;
        end
      end
      ST_ACK:
      begin
        if (!trap_ack)
        begin
          state_next = ST_SWAP;
        end
      end
    endcase
    if (raise)
    begin
      seg_trap_n_next = 1'b0;
    end
    else if (trap_ack)
    begin
      seg_trap_n_next = 1'b1;
    end
    hold_next = (hold_reg & ~instr_end) | (cpu_chk & viol & ~in_swap);
    if (acc_valid)
    begin
      suppress_n_next = ~sup_now;
    end
    else if (instr_end)
    begin
      suppress_n_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge lines
  // ----------------------------------------------------------------
  logic req_now;
  assign req_now = (state_reg == ST_ACK) ? ack_req_reg : trap_pend;

  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_ack_line
      always_comb
      begin
        ad_oe_next[i]  = trap_ack & mode_reg[STP_MODE_ENA_BIT] &
                         (unit_identifier_field == 3'(i));
        ad_out_next[i] = ad_oe_next[i] & req_now;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg      <= ST_RUN;
      seg_trap_n_reg <= 1'b1;
      suppress_n_reg <= 1'b1;
      hold_reg       <= 1'b0;
      ack_req_reg    <= 1'b0;
      ad_out_reg     <= STP_BYTE_RESET;
      ad_oe_reg      <= STP_BYTE_RESET;
    end
    else
    begin
      state_reg      <= state_next;
      seg_trap_n_reg <= seg_trap_n_next;
      suppress_n_reg <= suppress_n_next;
      hold_reg       <= hold_next;
      ack_req_reg    <= ack_req_next;
      ad_out_reg     <= ad_out_next;
      ad_oe_reg      <= ad_oe_next;
    end
  end

  // ----------------------------------------------------------------
  // Violation flags, capture and command port
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_next     = mode_reg;
    inst_seg_next = inst_seg_reg;
    inst_off_next = inst_off_reg;
    viol_seg_next = viol_seg_reg;
    viol_off_next = viol_off_reg;
    len_viol_next = len_viol_reg;
    pri_warn_next = pri_warn_reg;
    secondary_write_warning_flag_next = secondary_write_warning_flag_reg;
    fatal_condition_flag_next         = fatal_condition_flag_reg;
    frozen_next   = frozen_reg;
    if (reg_wr & (reg_addr == STP_ADDR_MODE))
    begin
      mode_next = reg_wdata;
    end
    // Clears first so that a same-cycle hardware set wins
    if (cmd_wr & reg_wdata[STP_CMD_CLR_ALL])
    begin
      len_viol_next = 1'b0;
      pri_warn_next = 1'b0;
      secondary_write_warning_flag_next = 1'b0;
      fatal_condition_flag_next         = 1'b0;
      frozen_next   = 1'b0;
    end
    if (cmd_wr & reg_wdata[STP_CMD_CLR_SEC])
    begin
      secondary_write_warning_flag_next = 1'b0;
    end
    if (cmd_wr & reg_wdata[STP_CMD_CLR_FATAL])
    begin
      fatal_condition_flag_next = 1'b0;
    end
    if (cpu_chk & viol & ~in_swap)
    begin
      len_viol_next = 1'b1;
    end
    if (cpu_chk & warn & ~in_swap)
    begin
      pri_warn_next = 1'b1;
    end
    if (cpu_chk & warn & in_swap)
    begin
      secondary_write_warning_flag_next = 1'b1;
    end
    if (cpu_chk & viol & in_swap)
    begin
      fatal_condition_flag_next = 1'b1;
    end
    // instruction capture
    // A trapping fetch does not load, so the previous one stays visible.
    if (cpu_chk & acc_fetch & ~raise & ~frozen_reg)
    begin
      inst_seg_next = acc_seg;
      inst_off_next = off_hi;
    end
    if (raise & ~frozen_reg)
    begin
      frozen_next   = 1'b1;
      viol_seg_next = acc_seg;
      viol_off_next = off_hi;
    end
    rdata_next = STP_BYTE_RESET;
    if (reg_rd)
    begin
      unique case (reg_addr)
        STP_ADDR_MODE:     rdata_next = mode_reg;
        STP_ADDR_STATUS:
        begin
          rdata_next[STP_ST_LEN_BIT]   = len_viol_reg;
          rdata_next[STP_ST_PRI_BIT]   = pri_warn_reg;
          rdata_next[STP_ST_SEC_BIT]   = secondary_write_warning_flag_reg;
          rdata_next[STP_ST_FATAL_BIT] = fatal_condition_flag_reg;
        end
        STP_ADDR_INST_SEG: rdata_next = {1'b0, inst_seg_reg};
        STP_ADDR_INST_OFF: rdata_next = inst_off_reg;
        STP_ADDR_VIOL_SEG: rdata_next = {1'b0, viol_seg_reg};
        STP_ADDR_VIOL_OFF: rdata_next = viol_off_reg;
        default:           rdata_next = STP_BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg      <= STP_MODE_RESET;
      inst_seg_reg  <= STP_SEG_RESET;
      inst_off_reg  <= STP_BYTE_RESET;
      viol_seg_reg  <= STP_SEG_RESET;
      viol_off_reg  <= STP_BYTE_RESET;
      len_viol_reg  <= 1'b0;
      pri_warn_reg  <= 1'b0;
      secondary_write_warning_flag_reg <= 1'b0;
      fatal_condition_flag_reg         <= 1'b0;
      frozen_reg    <= 1'b0;
      rdata_reg     <= STP_BYTE_RESET;
    end
    else
    begin
      mode_reg      <= mode_next;
      inst_seg_reg  <= inst_seg_next;
      inst_off_reg  <= inst_off_next;
      viol_seg_reg  <= viol_seg_next;
      viol_off_reg  <= viol_off_next;
      len_viol_reg  <= len_viol_next;
      pri_warn_reg  <= pri_warn_next;
      secondary_write_warning_flag_reg <= secondary_write_warning_flag_next;
      fatal_condition_flag_reg         <= fatal_condition_flag_next;
      frozen_reg    <= frozen_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign seg_trap_n = seg_trap_n_reg;
  assign suppress_n = suppress_n_reg;
  assign ad_hi_out  = ad_out_reg;
  assign ad_hi_oe   = ad_oe_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence ack_start_s;
    trap_ack && (state_reg != ST_ACK);
  endsequence

  sequence cpu_out_range_s;
    acc_valid && !acc_dma && !ignored && (state_reg != ST_ACK) &&
    !in_range && !fatal_condition_flag_reg && !trap_ack;
  endsequence

  trap_raise_a: assert property (cpu_out_range_s |=> !seg_trap_n)
    else $error("violation did not pull segment trap low");

  trap_hold_a: assert property ($rose(seg_trap_n) |-> $past(trap_ack))
    else $error("segment trap released without acknowledge");

  ack_release_a: assert property (ack_start_s |=> seg_trap_n)
    else $error("segment trap not released in acknowledge");

  ack_line_a: assert property (
    ack_start_s ##0 mode_reg[STP_MODE_ENA_BIT] |=>
      ($countones(ad_hi_oe) == 1) && ad_hi_oe[unit_identifier_field] &&
      (ad_hi_out[unit_identifier_field] == $past(trap_pend)))
    else $error("wrong acknowledge line or value");

  dma_no_trap_a: assert property (
    acc_valid && acc_dma && seg_trap_n && !trap_ack &&
    !(cpu_chk && raise) |=> seg_trap_n)
    else $error("DMA check raised a segment trap");

  dma_clean_a: assert property (
    chk && acc_dma && in_range |=> suppress_n)
    else $error("legal DMA cycle was suppressed");

  swap_nosup_a: assert property (
    in_swap && acc_valid && !acc_dma |=> suppress_n)
    else $error("suppress during context swap store");

  hold_sup_a: assert property (
    cpu_chk && hold_reg && !in_swap |=> !suppress_n)
    else $error("suppress dropped before instruction end");

  warn_nosup_a: assert property (
    cpu_chk && warn && !in_swap && !hold_reg &&
    !secondary_write_warning_flag_reg |=> suppress_n && !seg_trap_n)
    else $error("write warning not trap-only");

  sec_block_a: assert property (
    cpu_chk && warn && secondary_write_warning_flag_reg && seg_trap_n &&
    !trap_ack |=> seg_trap_n)
    else $error("warning trapped with secondary flag set");

  fatal_block_a: assert property (
    cpu_chk && viol && fatal_condition_flag_reg && seg_trap_n &&
    !trap_ack |=> seg_trap_n)
    else $error("violation trapped with fatal flag set");

  freeze_a: assert property (
    frozen_reg && !cmd_wr |=> $stable(inst_seg_reg) &&
    $stable(inst_off_reg))
    else $error("instruction capture moved while frozen");

endmodule // stp_segment_trap

// ---- design/stp_pkg.sv ----
// Constants and types for the segment range check and trap block
//
// Functional notes
// - Check each offset against the range; outside it, trap and suppress.
// - Ordinary segment: offsets 0 to 256 times limit plus 255 are legal.
// - Stack segment: offsets 256 times limit to 65535 are legal.
// - Stack segment write into lowest 256 bytes traps without suppress.
// - Trap on violation or write warning; suppress only on violation.
// - Segment trap output stays low until trap acknowledge arrives.
// - CPU violation suppresses all CPU references until instruction end.
// - DMA cycles are suppressed only when they violate, for that cycle only.
// - No trap request ever comes from a check made during DMA.
// - Aborted fetch before the acknowledge cycle is ignored by the checker.
// - Acknowledge: line 8 plus identifier is one if requested, else zero.
// - Drive only the own acknowledge line; all other lines stay released.
// - Segment trap output is released within the acknowledge cycle.
// - No suppress for the status and counter stores after acknowledge.
// - Swap warning sets the secondary warning flag and a new trap.
// - With secondary warning flag set, write warnings raise no trap.
// - Swap violation sets fatal flag; later violations suppress, no trap.
// - Capture segment and upper offset byte of the last instruction fetch.
// - Fetch trap keeps the previous instruction; data trap its issuer.
// - Three-bit unit identifier picks the acknowledge line; eight units.
// - DMA violation suppresses but leaves trap capture registers alone.
package stp_pkg;

  // ----------------------------------------------------------------
  // Register indices on the command port
  // ----------------------------------------------------------------
  localparam logic [3:0] STP_ADDR_MODE     = 4'h0;
  localparam logic [3:0] STP_ADDR_STATUS   = 4'h1;
  localparam logic [3:0] STP_ADDR_INST_SEG = 4'h2;
  localparam logic [3:0] STP_ADDR_INST_OFF = 4'h3;
  localparam logic [3:0] STP_ADDR_VIOL_SEG = 4'h4;
  localparam logic [3:0] STP_ADDR_VIOL_OFF = 4'h5;
  localparam logic [3:0] STP_ADDR_CMD      = 4'h6;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         STP_MODE_ENA_BIT  = 7;
  localparam int         STP_MODE_UNIT_LSB = 0;
  localparam int         STP_UNIT_W        = 3;
  localparam int         STP_ST_LEN_BIT    = 0;
  localparam int         STP_ST_PRI_BIT    = 1;
  localparam int         STP_ST_SEC_BIT    = 2;
  localparam int         STP_ST_FATAL_BIT  = 3;
  localparam int         STP_CMD_CLR_ALL   = 0;
  localparam int         STP_CMD_CLR_SEC   = 1;
  localparam int         STP_CMD_CLR_FATAL = 2;
  localparam int         STP_ACK_LINE_BASE = 8;
  localparam logic [7:0] STP_MODE_RESET    = 8'h00;
  localparam logic [7:0] STP_BYTE_RESET    = 8'h00;
  localparam logic [6:0] STP_SEG_RESET     = 7'h00;

  typedef enum logic [1:0] {ST_RUN, ST_ACK, ST_SWAP} stp_state_t;

endpackage : stp_pkg

// ---- tb/stp_bus_model.sv ----
// Processor and DMA bus masters that present cycles to the trap block
`timescale 1ns/1ns
module stp_bus_model (
  // Clock
  input  wire logic        clk_sys,
  // Bus cycle toward the checker
  output logic             acc_valid,
  output logic             acc_dma,
  output logic             acc_fetch,
  output logic             acc_write,
  output logic      [6:0]  acc_seg,
  output logic      [15:0] acc_off,
  output logic      [7:0]  seg_limit,
  output logic             stack_direction_warning_flag,
  // Processor sequencing
  output logic             instr_end,
  output logic             trap_ack
);
  initial
  begin
    acc_valid = 1'h0;
    acc_dma = 1'h0;
    acc_fetch = 1'h0;
    acc_write = 1'h0;
    acc_seg = 7'h00;
    acc_off = 16'h0000;
    seg_limit = 8'h00;
    stack_direction_warning_flag = 1'h0;
    instr_end = 1'h0;
    trap_ack = 1'h0;
  end

  // Holds the cycle up to the edge that samples it
  task automatic cyc(input logic d, f, w, input logic [6:0] s,
                     input logic [15:0] o, input logic [7:0] l,
                     input logic dw);
    acc_valid <= 1'h1;
    acc_dma <= d;
    acc_fetch <= f;
    acc_write <= w;
    acc_seg <= s;
    acc_off <= o;
    seg_limit <= l;
    stack_direction_warning_flag <= dw;
    @(posedge clk_sys);
  endtask

  task automatic idle();
    acc_valid <= 1'h0;
    // Idle bus does not keep the last offset
    acc_off <= ~acc_off;
    @(posedge clk_sys);
  endtask

  task automatic iend();
    instr_end <= 1'h1;
    @(posedge clk_sys);
    instr_end <= 1'h0;
  endtask

  task automatic ack_begin(input logic [15:0] fo);
    cyc(1'h0, 1'h1, 1'h0, 7'h7F, fo, 8'h00, 1'h0);
    idle();
    trap_ack <= 1'h1;
    @(posedge clk_sys);
    @(posedge clk_sys);
  endtask

  task automatic ack_end();
    trap_ack <= 1'h0;
    @(posedge clk_sys);
  endtask
endmodule // stp_bus_model

// ---- tb/stp_segment_trap_tb_top.sv ----
// Self-checking bench for the segment range check and trap block
`timescale 1ns/1ns
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      $display("[ERR] %s expected %h seen %h", n, e, g); \
      failures++; \
    end \
  end
module stp_segment_trap_tb_top
  import stp_pkg::*;
;
  logic        clk_sys   = 1'h0;
  logic        arst_n    = 1'h0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'h0;
  logic        reg_rd    = 1'h0;
  logic [7:0]  reg_rdata, ad_hi_out, ad_hi_oe;
  logic        seg_trap_n, suppress_n, acc_valid, acc_dma, acc_fetch;
  logic        acc_write, instr_end, trap_ack;
  logic        stack_direction_warning_flag;
  logic [6:0]  acc_seg;
  logic [15:0] acc_off;
  logic [7:0]  seg_limit;
  int          failures = 0;
  int          samples_checked = 0;

  always #50 clk_sys = ~clk_sys;

  stp_bus_model stp_bus_model_inst (
    .clk_sys(clk_sys), .acc_valid(acc_valid), .acc_dma(acc_dma),
    .acc_fetch(acc_fetch), .acc_write(acc_write), .acc_seg(acc_seg),
    .acc_off(acc_off), .seg_limit(seg_limit),
    .stack_direction_warning_flag(stack_direction_warning_flag),
    .instr_end(instr_end), .trap_ack(trap_ack));

  stp_segment_trap stp_segment_trap_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .acc_valid(acc_valid),
    .acc_dma(acc_dma), .acc_fetch(acc_fetch), .acc_write(acc_write),
    .acc_seg(acc_seg), .acc_off(acc_off), .seg_limit(seg_limit),
    .stack_direction_warning_flag(stack_direction_warning_flag),
    .instr_end(instr_end),
    .trap_ack(trap_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .seg_trap_n(seg_trap_n), .suppress_n(suppress_n),
    .ad_hi_out(ad_hi_out), .ad_hi_oe(ad_hi_oe));

  task automatic final_report();
    if (failures == 0 && samples_checked > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] m, e);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    `CHK("reg_rdata", e, reg_rdata & m)
  endtask

  task automatic acc(input logic d, f, w, input logic [6:0] s,
                     input logic [15:0] o, input logic [7:0] l,
                     input logic dw, es, et);
    stp_bus_model_inst.cyc(d, f, w, s, o, l, dw);
    #1;
    `CHK("suppress_n", es, suppress_n)
    `CHK("seg_trap_n", et, seg_trap_n)
    stp_bus_model_inst.idle();
  endtask

  task automatic eoi();
    stp_bus_model_inst.iend();
    #1;
    `CHK("suppress_n", 1'h1, suppress_n)
  endtask

  task automatic ack(input logic [15:0] fo, input logic [7:0] oe, out);
    stp_bus_model_inst.ack_begin(fo);
    #1;
    `CHK("seg_trap_n", 1'h1, seg_trap_n)
    `CHK("suppress_n", 1'h1, suppress_n)
    `CHK("ad_hi_oe", oe, ad_hi_oe)
    `CHK("ad_hi_out", out, ad_hi_out)
    stp_bus_model_inst.ack_end();
    #1;
    `CHK("ad_hi_oe", 8'h00, ad_hi_oe)
  endtask

  // Guards against a hang anywhere in the sequence
  initial
  begin
    #5_000_000;
    failures++;
    final_report();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
    #1;
    `CHK("seg_trap_n", 1'h1, seg_trap_n)
    `CHK("ad_hi_oe", 8'h00, ad_hi_oe)
    for (int i = 0; i < 6; i++) rd(4'(i), 8'hFF, 8'h00);
    rd(4'hF, 8'hFF, 8'h00);
    wr(STP_ADDR_MODE, 8'h85);
    wr(STP_ADDR_STATUS, 8'hFF);
    rd(STP_ADDR_MODE, 8'hFF, 8'h85);
    rd(STP_ADDR_STATUS, 8'hFF, 8'h00);
    acc(1'h0, 1'h1, 1'h0, 7'h03, 16'h2200, 8'h40, 1'h0, 1'h1, 1'h1);
    acc(1'h0, 1'h0, 1'h0, 7'h03, 16'h40FF, 8'h40, 1'h0, 1'h1, 1'h1);
    acc(1'h0, 1'h0, 1'h0, 7'h03, 16'h4000, 8'h40, 1'h1, 1'h1, 1'h1);
    acc(1'h0, 1'h0, 1'h1, 7'h03, 16'hFFFF, 8'h40, 1'h1, 1'h1, 1'h1);
    acc(1'h1, 1'h0, 1'h0, 7'h11, 16'h3FFF, 8'h40, 1'h1, 1'h0, 1'h1);
    acc(1'h1, 1'h0, 1'h1, 7'h11, 16'h4000, 8'h40, 1'h1, 1'h1, 1'h1);
    rd(STP_ADDR_VIOL_SEG, 8'hFF, 8'h00);
    rd(STP_ADDR_STATUS, 8'hFF, 8'h00);
    acc(1'h0, 1'h0, 1'h0, 7'h05, 16'h4100, 8'h40, 1'h0, 1'h0, 1'h0);
    acc(1'h0, 1'h0, 1'h0, 7'h05, 16'h0000, 8'h40, 1'h0, 1'h0, 1'h0);
    acc(1'h1, 1'h0, 1'h0, 7'h05, 16'h0000, 8'h40, 1'h0, 1'h1, 1'h0);
    acc(1'h0, 1'h0, 1'h0, 7'h05, 16'h0010, 8'h40, 1'h0, 1'h0, 1'h0);
    eoi();
    rd(STP_ADDR_STATUS, 8'hFF, 8'h01);
    rd(STP_ADDR_INST_SEG, 8'hFF, 8'h03);
    rd(STP_ADDR_INST_OFF, 8'hFF, 8'h22);
    rd(STP_ADDR_VIOL_SEG, 8'hFF, 8'h05);
    rd(STP_ADDR_VIOL_OFF, 8'hFF, 8'h41);
    ack(16'hFF00, 8'h20, 8'h20);
    rd(STP_ADDR_INST_SEG, 8'hFF, 8'h03);
    acc(1'h0, 1'h0, 1'h1, 7'h02, 16'h0150, 8'h01, 1'h1, 1'h1, 1'h0);
    rd(STP_ADDR_STATUS, 8'h04, 8'h04);
    ack(16'hFF00, 8'h20, 8'h20);
    acc(1'h0, 1'h0, 1'h1, 7'h02, 16'h0140, 8'h01, 1'h1, 1'h1, 1'h1);
    acc(1'h0, 1'h0, 1'h1, 7'h02, 16'h0300, 8'h01, 1'h0, 1'h1, 1'h0);
    ack(16'hFF00, 8'h20, 8'h20);
    acc(1'h0, 1'h1, 1'h0, 7'h09, 16'h0000, 8'h00, 1'h0, 1'h1, 1'h1);
    acc(1'h0, 1'h0, 1'h0, 7'h09, 16'h0500, 8'h02, 1'h0, 1'h0, 1'h1);
    rd(STP_ADDR_STATUS, 8'h0C, 8'h0C);
    eoi();
    acc(1'h0, 1'h0, 1'h1, 7'h02, 16'h0150, 8'h01, 1'h1, 1'h1, 1'h1);
    wr(STP_ADDR_CMD, 8'h04);
    rd(STP_ADDR_STATUS, 8'h0A, 8'h02);
    wr(STP_ADDR_CMD, 8'h02);
    rd(STP_ADDR_STATUS, 8'h04, 8'h00);
    acc(1'h0, 1'h0, 1'h1, 7'h02, 16'h0150, 8'h01, 1'h1, 1'h1, 1'h0);
    ack(16'hFF00, 8'h20, 8'h20);
    wr(STP_ADDR_CMD, 8'h01);
    rd(STP_ADDR_STATUS, 8'hFF, 8'h00);
    acc(1'h0, 1'h1, 1'h0, 7'h0A, 16'h1200, 8'h20, 1'h0, 1'h1, 1'h1);
    rd(STP_ADDR_INST_SEG, 8'hFF, 8'h0A);
    rd(STP_ADDR_INST_OFF, 8'hFF, 8'h12);
    acc(1'h0, 1'h1, 1'h0, 7'h0B, 16'h3300, 8'h20, 1'h0, 1'h0, 1'h0);
    rd(STP_ADDR_INST_SEG, 8'hFF, 8'h0A);
    rd(STP_ADDR_VIOL_SEG, 8'hFF, 8'h0B);
    rd(STP_ADDR_VIOL_OFF, 8'hFF, 8'h33);
    wr(STP_ADDR_MODE, 8'h05);
    eoi();
    ack(16'hFF00, 8'h00, 8'h00);
    acc(1'h0, 1'h1, 1'h0, 7'h0A, 16'h0000, 8'h20, 1'h0, 1'h1, 1'h1);
    wr(STP_ADDR_MODE, 8'h87);
    ack(16'h0000, 8'h80, 8'h00);
    final_report();
  end
endmodule // stp_segment_trap_tb_top
